// ### hw/ext_err_pkg.sv
// Constants for the external interface error logging registers.
// Assumes a 64-bit internal register read path with 40-bit addresses.
package ext_err_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam int          ADDR_W          = 40;
  localparam int          DATA_W          = 64;
  localparam logic [39:0] ADDR_FILL_SYNDROME   = 40'hfffff00068;
  localparam logic [39:0] ADDR_TAG_CAP    = 40'hfffff00108;
  localparam logic [39:0] ADDR_ERR_ADDR   = 40'hfffff00148;
  localparam logic [39:0] ADDR_ERR_STATUS = 40'hfffff00168;

  // ----------------------------------------
  // Tag capture fields
  // ----------------------------------------
  localparam int TC_HIT    = 12;
  localparam int TC_CTLP   = 13;
  localparam int TC_DIRTY  = 14;
  localparam int TC_SHARED = 15;
  localparam int TC_VALID  = 16;
  localparam int TC_TAGP   = 17;
  localparam int TC_TAG_LO = 20;
  localparam int TC_TAG_HI = 38;
  localparam int TAG_W     = TC_TAG_HI - TC_TAG_LO + 1;

  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int ST_REV_LO = 24;
  localparam int ST_REV_HI = 27;
  localparam int ST_TPE    = 28;
  localparam int ST_TCPE   = 29;
  localparam int ST_SRC    = 30;
  localparam int ST_COR    = 31;
  localparam int ST_UNC    = 32;
  localparam int ST_PAR    = 33;
  localparam int ST_IRD    = 34;
  localparam int ST_SECOND = 35;

  // Revision identifier, value arbitrary
  localparam logic [3:0] REVISION_ID_DEF = 4'h9;

  // Other widths
  localparam int SYN_W      = 16;
  localparam int ERR_ADDR_W = 40;

endpackage

// ### hw/err_lock_if.sv
// Carrier between the data capture logic and the lock controller.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface err_lock_if;
  logic ev_corr;
  logic ev_unc;
  logic ev_par;
  logic ev_tpe;
  logic ev_tcpe;
  logic stat_rd;
  logic load;
  logic locked;
  logic cor;
  logic unc;
  logic par;
  logic tpe;
  logic tcpe;
  logic second;
  modport ctrl (input ev_corr, ev_unc, ev_par, ev_tpe, ev_tcpe, stat_rd,
                output load, locked, cor, unc, par, tpe, tcpe, second);
  modport user (output ev_corr, ev_unc, ev_par, ev_tpe, ev_tcpe, stat_rd,
                input load, locked, cor, unc, par, tpe, tcpe, second);
endinterface
`default_nettype wire

// ### hw/err_lock_ctrl.sv
// Status bits and lock state of the error logging registers.
// Assumes events are one-cycle pulses; state is not reset.
`timescale 1ns/1ps
`default_nettype none
module err_lock_ctrl (
  input  wire logic  ref_clk_i,
  input  wire logic  rst_b_i,
  err_lock_if.ctrl   lk
);
  logic hard_set;
  logic c_a, u_a, p_a, tp_a, tc_a, s_a, l_a;
  logic any_hard;

  // ----------------------------------------
  // Read effect, then event effect
  // ----------------------------------------
  assign hard_set = lk.unc | lk.par | lk.tpe | lk.tcpe;
  assign any_hard = lk.ev_unc | lk.ev_par | lk.ev_tpe | lk.ev_tcpe;

  always_comb begin
    {c_a, u_a, p_a, tp_a, tc_a, s_a, l_a} = {lk.cor, lk.unc, lk.par, lk.tpe, lk.tcpe, lk.second, lk.locked};
    if (lk.stat_rd) begin
      if (lk.cor && hard_set) begin
        c_a = 1'b0;
      end else begin
        {c_a, u_a, p_a, tp_a, tc_a, s_a, l_a} = 7'h00;
      end
    end
  end

  assign lk.load = (any_hard && !(u_a | p_a | tp_a | tc_a))
                 || (!any_hard && lk.ev_corr && !c_a && !l_a);

  always_ff @(posedge ref_clk_i) begin
    {lk.cor, lk.unc, lk.par, lk.tpe, lk.tcpe, lk.second, lk.locked} <= {c_a, u_a, p_a, tp_a, tc_a, s_a, l_a};
    if (any_hard) begin
      if (!(u_a | p_a | tp_a | tc_a)) begin
        lk.unc    <= lk.ev_unc;
        lk.par    <= lk.ev_par;
        lk.tpe    <= lk.ev_tpe;
        lk.tcpe   <= lk.ev_tcpe;
        lk.locked <= 1'b1;
      end else if (lk.ev_unc || lk.ev_par) begin
        lk.second <= 1'b1;
      end
    end else if (lk.ev_corr && !c_a && !l_a) begin
      lk.cor <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_corr_no_lock;
    lk.ev_corr && !any_hard && !lk.stat_rd && !lk.locked && !lk.cor |-> lk.load ##1 lk.cor && !lk.locked;
  endproperty
  a_corr_no_lock: assert property (p_corr_no_lock) else $error("first correctable must load without lock");
  property p_second_hard;
    lk.locked && lk.unc && lk.ev_unc && !lk.stat_rd |-> !lk.load ##1 lk.second && lk.locked;
  endproperty
  a_second_hard: assert property (p_second_hard) else $error("second hard error not flagged");
  property p_cor_after_unc;
    lk.unc && !lk.second && lk.ev_corr && !any_hard && !lk.stat_rd |=> !lk.second && !lk.cor;
  endproperty
  a_cor_after_unc: assert property (p_cor_after_unc) else $error("correctable logged after hard error");
  property p_both_read;
    lk.stat_rd && lk.cor && lk.unc && !any_hard && !lk.ev_corr |=> !lk.cor && lk.unc && lk.locked && $stable(lk.second);
  endproperty
  a_both_read: assert property (p_both_read) else $error("both-set read mishandled");
  property p_plain_read;
    lk.stat_rd && !(lk.cor && hard_set) && !any_hard && !lk.ev_corr |=> !lk.locked && !lk.cor && !lk.unc && !lk.second;
  endproperty
  a_plain_read: assert property (p_plain_read) else $error("status read did not clear");
  c_both_read: cover property (lk.stat_rd && lk.cor && lk.unc);
  c_second: cover property (lk.ev_unc && lk.unc);
endmodule
`default_nettype wire

// ### hw/ext_error_log_regs.sv
// External interface error logging registers: tag capture, error
// address, fill syndrome and status, read over the internal register path.
// Assumes all inputs are synchronous to ref_clk_i and events are pulses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Tag capture bit 12 shows hit
// - Dirty, shared, valid at 14, 15, 16
// - Control parity bit 13, tag parity 17
// - Tag bits 38:20, unused bits zero
// - Status read unlocks and clears status
// - Other register reads change nothing
// - Reset keeps logged state and locks
// - ECC mode splits; parity mode uncorrectable
// - Command parity errors always uncorrectable
// - Correctable loads once, never locks
// - First uncorrectable loads and locks
// - Correctable after uncorrectable not second error
// - Tag parity errors count as uncorrectable
// - Both set: clear correctable, stay locked
// - Otherwise read clears all and unlocks
// - Status bits 27:24 give revision
// - Status 28 tag, 29 control parity
// - Status 30 gives error source
// - Status 31, 32, 33 error kinds
// - Status 35 marks second uncorrectable or command parity error
// - Tag capture follows reads until locked
// - Error address holds logged address
module ext_error_log_regs
  import ext_err_pkg::*;
#(
  parameter logic [3:0] REVISION_ID = ext_err_pkg::REVISION_ID_DEF
) (
  input  wire logic                                ref_clk_i,
  input  wire logic                                rst_b_i,
  input  wire logic                                rd_en_i,
  input  wire logic [ext_err_pkg::ADDR_W-1:0]      rd_addr_i,
  output logic                                     rd_valid_o,
  output logic      [ext_err_pkg::DATA_W-1:0]      rd_data_o,
  input  wire logic                                ecc_mode_i,
  input  wire logic                                tag_rd_i,
  input  wire logic                                tag_hit_i,
  input  wire logic [ext_err_pkg::TAG_W-1:0]       tag_bits_i,
  input  wire logic [ext_err_pkg::TAG_W-1:0]       tag_used_mask_i,
  input  wire logic                                tag_parity_i,
  input  wire logic                                status_parity_bit_i,
  input  wire logic                                line_dirty_bit_i,
  input  wire logic                                line_shared_bit_i,
  input  wire logic                                line_valid_bit_i,
  input  wire logic                                tag_addr_parity_err_i,
  input  wire logic                                tag_ctl_parity_err_i,
  input  wire logic                                fill_err_i,
  input  wire logic                                fill_err_correctable_i,
  input  wire logic                                fill_from_memory_i,
  input  wire logic                                instruction_fill_flag_i,
  input  wire logic [ext_err_pkg::ERR_ADDR_W-1:0]  fill_addr_i,
  input  wire logic [ext_err_pkg::SYN_W-1:0]       fill_syndrome_i,
  input  wire logic                                cmd_addr_parity_err_i,
  input  wire logic [ext_err_pkg::ERR_ADDR_W-1:0]  cmd_addr_i
);
  import ext_err_pkg::*;

  err_lock_if lk ();

  logic                  hit;
  logic                  ctl_par;
  logic                  dirty;
  logic                  shared;
  logic                  valid;
  logic                  tag_par;
  logic [TAG_W-1:0]      tag;
  logic                  src_mem;
  logic                  ird;
  logic [ERR_ADDR_W-1:0] error_address;
  logic [SYN_W-1:0]      fill_syndrome;
  logic [DATA_W-1:0]     cache_tag_capture;
  logic [DATA_W-1:0]     error_status;
  logic [DATA_W-1:0]     next_rd_data;
  logic                  fill_evt;
  logic                  stat_hard;

  // ----------------------------------------
  // Error classification
  // ----------------------------------------
  assign fill_evt = fill_err_i;
  assign stat_hard = lk.unc | lk.par | lk.tpe | lk.tcpe;
  assign lk.ev_corr = fill_err_i && ecc_mode_i && fill_err_correctable_i;
  assign lk.ev_unc  = fill_err_i && !(ecc_mode_i && fill_err_correctable_i);
  assign lk.ev_par  = cmd_addr_parity_err_i;
  assign lk.ev_tpe  = tag_rd_i && tag_addr_parity_err_i;
  assign lk.ev_tcpe = tag_rd_i && tag_ctl_parity_err_i;
  assign lk.stat_rd = rd_en_i && (rd_addr_i == ADDR_ERR_STATUS);

  err_lock_ctrl u_lock (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .lk        (lk)
  );

  // ----------------------------------------
  // Tag capture
  // ----------------------------------------
  // follow tag reads while unlocked
  always_ff @(posedge ref_clk_i) begin
    if (tag_rd_i && !lk.locked) begin
      hit     <= tag_hit_i;
      ctl_par <= status_parity_bit_i;
      dirty   <= line_dirty_bit_i;
      shared  <= line_shared_bit_i;
      valid   <= line_valid_bit_i;
      tag_par <= tag_parity_i;
      tag     <= tag_bits_i & tag_used_mask_i;
    end
  end

  // ----------------------------------------
  // Error address, syndrome, source
  // ----------------------------------------
  // logged address on load
  always_ff @(posedge ref_clk_i) begin
    if (lk.load) begin
      error_address <= (cmd_addr_parity_err_i && !fill_evt) ? cmd_addr_i : fill_addr_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (lk.load && fill_evt) begin
      fill_syndrome <= fill_syndrome_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (lk.stat_rd) begin
      if (lk.cor && stat_hard) begin
        src_mem <= src_mem;
        ird     <= ird;
      end else begin
        src_mem <= 1'b0;
        ird     <= 1'b0;
      end
    end
    if (lk.load) begin
      src_mem <= fill_evt ? fill_from_memory_i : cmd_addr_parity_err_i;
      ird     <= fill_evt && instruction_fill_flag_i;
    end
  end

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  always_comb begin
    cache_tag_capture                       = '0;
    cache_tag_capture[TC_HIT]               = hit;
    cache_tag_capture[TC_CTLP]              = ctl_par;
    cache_tag_capture[TC_TAGP]              = tag_par;
    cache_tag_capture[TC_DIRTY]             = dirty;
    cache_tag_capture[TC_SHARED]            = shared;
    cache_tag_capture[TC_VALID]             = valid;
    cache_tag_capture[TC_TAG_HI:TC_TAG_LO]  = tag;
  end

  always_comb begin
    error_status                       = '0;
    error_status[ST_REV_HI:ST_REV_LO]  = REVISION_ID;
    error_status[ST_TPE]               = lk.tpe;
    error_status[ST_TCPE]              = lk.tcpe;
    error_status[ST_SRC]               = src_mem;
    error_status[ST_COR]               = lk.cor;
    error_status[ST_UNC]               = lk.unc;
    error_status[ST_PAR]               = lk.par;
    error_status[ST_IRD]               = ird;
    error_status[ST_SECOND]            = lk.second;
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // plain reads have no side effect
  always_comb begin
    next_rd_data = '0;
    unique case (rd_addr_i)
      ADDR_ERR_STATUS: begin
        next_rd_data = error_status;
      end
      ADDR_TAG_CAP: begin
        next_rd_data = cache_tag_capture;
      end
      ADDR_ERR_ADDR: begin
        next_rd_data[ERR_ADDR_W-1:0] = error_address;
      end
      ADDR_FILL_SYNDROME: begin
        next_rd_data[SYN_W-1:0] = fill_syndrome;
      end
      default: begin
        next_rd_data = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= next_rd_data;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_hit_bit;
    tag_rd_i && !lk.locked ##1 !tag_rd_i ##1 rd_en_i && rd_addr_i == ADDR_TAG_CAP
      |=> rd_data_o[TC_HIT] == $past(tag_hit_i, 3);
  endproperty
  a_hit_bit: assert property (p_hit_bit) else $error("hit bit not at position 12");

  property p_ctl_bits;
    tag_rd_i && !lk.locked |=> cache_tag_capture[TC_VALID:TC_DIRTY]
      == $past({line_valid_bit_i, line_shared_bit_i, line_dirty_bit_i});
  endproperty
  a_ctl_bits: assert property (p_ctl_bits) else $error("tag control bits misplaced");

  property p_par_bits;
    tag_rd_i && !lk.locked |=> cache_tag_capture[TC_CTLP] == $past(status_parity_bit_i)
      && cache_tag_capture[TC_TAGP] == $past(tag_parity_i);
  endproperty
  a_par_bits: assert property (p_par_bits) else $error("tag parity bits misplaced");

  property p_tag_field;
    tag_rd_i && !lk.locked |=> cache_tag_capture[TC_TAG_HI:TC_TAG_LO]
      == ($past(tag_bits_i) & $past(tag_used_mask_i));
  endproperty
  a_tag_field: assert property (p_tag_field) else $error("tag field wrong or unused bits set");

  property p_tag_locked;
    lk.locked && !lk.stat_rd ##1 tag_rd_i |=> $stable(cache_tag_capture);
  endproperty
  a_tag_locked: assert property (p_tag_locked) else $error("tag capture changed while locked");

  property p_no_side_effect;
    rd_en_i && rd_addr_i != ADDR_ERR_STATUS && !fill_err_i && !cmd_addr_parity_err_i && !tag_rd_i
      |=> $stable(lk.locked) && $stable(error_status);
  endproperty
  a_no_side_effect: assert property (p_no_side_effect) else $error("non-status read changed state");

  property p_revision;
    rd_en_i && rd_addr_i == ADDR_ERR_STATUS |=> rd_valid_o && rd_data_o[ST_REV_HI:ST_REV_LO] == REVISION_ID;
  endproperty
  a_revision: assert property (p_revision) else $error("revision field wrong");

  property p_parity_mode;
    fill_err_i && !ecc_mode_i |-> !lk.ev_corr ##1 (lk.unc || lk.par || lk.tpe || lk.tcpe);
  endproperty
  a_parity_mode: assert property (p_parity_mode) else $error("parity mode error not hard");

  property p_cmd_parity;
    cmd_addr_parity_err_i |=> lk.par || lk.second || lk.unc || lk.tpe || lk.tcpe;
  endproperty
  a_cmd_parity: assert property (p_cmd_parity) else $error("command parity error not hard");

  property p_tag_err_lock;
    tag_rd_i && (tag_addr_parity_err_i || tag_ctl_parity_err_i) |=> lk.locked;
  endproperty
  a_tag_err_lock: assert property (p_tag_err_lock) else $error("tag parity error did not lock");

  property p_status_read_zero;
    rd_en_i && rd_addr_i == ADDR_ERR_STATUS |=> rd_data_o[DATA_W-1:ST_SECOND+1] == '0
      && rd_data_o[ST_REV_LO-1:0] == '0;
  endproperty
  a_status_read_zero: assert property (p_status_read_zero) else $error("undefined status bits nonzero");

  property p_tag_read_zero;
    rd_en_i && rd_addr_i == ADDR_TAG_CAP |=> rd_data_o[DATA_W-1:TC_TAG_HI+1] == '0
      && rd_data_o[TC_TAG_LO-1:TC_TAGP+1] == '0 && rd_data_o[TC_HIT-1:0] == '0;
  endproperty
  a_tag_read_zero: assert property (p_tag_read_zero) else $error("undefined tag capture bits nonzero");

  // ----------------------------------------
  // Logged value checks
  // ----------------------------------------
  property p_addr_load;
    lk.load && fill_err_i |=> error_address == $past(fill_addr_i) && fill_syndrome == $past(fill_syndrome_i);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("fill address or syndrome not loaded");

  property p_cmd_addr;
    lk.load && cmd_addr_parity_err_i && !fill_err_i |=> error_address == $past(cmd_addr_i) && src_mem && !ird;
  endproperty
  a_cmd_addr: assert property (p_cmd_addr) else $error("command error address not loaded");

  property p_source;
    lk.load && fill_err_i |=> src_mem == $past(fill_from_memory_i) && ird == $past(instruction_fill_flag_i);
  endproperty
  a_source: assert property (p_source) else $error("fill source or kind not logged");

  property p_tag_only;
    lk.load && !fill_err_i && !cmd_addr_parity_err_i |=> !src_mem && !ird;
  endproperty
  a_tag_only: assert property (p_tag_only) else $error("tag error set source or fill kind");

  property p_src_clear;
    lk.stat_rd && !lk.cor && !lk.load |=> !src_mem && !ird;
  endproperty
  a_src_clear: assert property (p_src_clear) else $error("status read left source or fill kind set");

  property p_log_locked;
    lk.locked && !lk.stat_rd |=> $stable(error_address) && $stable(fill_syndrome)
      && $stable(src_mem) && $stable(ird);
  endproperty
  a_log_locked: assert property (p_log_locked) else $error("logged values changed while locked");

  c_tag_lock: cover property (tag_rd_i && tag_addr_parity_err_i && !lk.locked);
  c_cmd_second: cover property (lk.ev_par && lk.locked);
  c_status_read: cover property (lk.stat_rd && lk.locked);
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the external interface error logging registers.
// Assumes the package, carrier and design files under hw/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ext_err_pkg::*;
  // Revision value, arbitrary
  localparam logic [3:0] RID = 4'h6;
  localparam logic [63:0] M_TAGERR = ~((64'h1 << ST_SRC) | (64'h1 << ST_IRD));
  localparam logic [63:0] M_CMD = ~(64'h1 << ST_IRD);
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic rd_en_i = 1'b0, ecc_mode_i = 1'b1, tag_rd_i = 1'b0, tag_hit_i = 1'b0;
  logic tag_parity_i = 1'b0, status_parity_bit_i = 1'b0, line_dirty_bit_i = 1'b0;
  logic line_shared_bit_i = 1'b0, line_valid_bit_i = 1'b0, tag_addr_parity_err_i = 1'b0;
  logic tag_ctl_parity_err_i = 1'b0, fill_err_i = 1'b0, fill_err_correctable_i = 1'b0;
  logic fill_from_memory_i = 1'b0, instruction_fill_flag_i = 1'b0, cmd_addr_parity_err_i = 1'b0;
  logic [39:0] rd_addr_i = 40'h0, fill_addr_i = 40'h0, cmd_addr_i = 40'h0, a1, a2;
  logic [18:0] tag_bits_i = 19'h0, tag_used_mask_i = 19'h7ffff;
  logic [15:0] fill_syndrome_i = 16'h0, s1, s2;
  logic        rd_valid_o;
  logic [63:0] rd_data_o, exp_tc, r;
  int          mismatches = 0;
  int          tests_run = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  ext_error_log_regs #(.REVISION_ID(RID)) u_ext_error_log_regs (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .ecc_mode_i(ecc_mode_i), .tag_rd_i(tag_rd_i),
    .tag_hit_i(tag_hit_i), .tag_bits_i(tag_bits_i), .tag_used_mask_i(tag_used_mask_i),
    .tag_parity_i(tag_parity_i), .status_parity_bit_i(status_parity_bit_i),
    .line_dirty_bit_i(line_dirty_bit_i), .line_shared_bit_i(line_shared_bit_i),
    .line_valid_bit_i(line_valid_bit_i), .tag_addr_parity_err_i(tag_addr_parity_err_i),
    .tag_ctl_parity_err_i(tag_ctl_parity_err_i), .fill_err_i(fill_err_i),
    .fill_err_correctable_i(fill_err_correctable_i), .fill_from_memory_i(fill_from_memory_i),
    .instruction_fill_flag_i(instruction_fill_flag_i), .fill_addr_i(fill_addr_i),
    .fill_syndrome_i(fill_syndrome_i), .cmd_addr_parity_err_i(cmd_addr_parity_err_i),
    .cmd_addr_i(cmd_addr_i));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("counts: tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [63:0] st(input bit cor, unc, par, tpe, tcpe, src, ird, sec);
    logic [63:0] v;
    v = '0;
    v[ST_REV_HI:ST_REV_LO] = RID;
    v[ST_COR] = cor;
    v[ST_UNC] = unc;
    v[ST_PAR] = par;
    v[ST_TPE] = tpe;
    v[ST_TCPE] = tcpe;
    v[ST_SRC] = src;
    v[ST_IRD] = ird;
    v[ST_SECOND] = sec;
    return v;
  endfunction

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic rdchk(input string n, input logic [39:0] a, input logic [63:0] exp,
                       input logic [63:0] m = '1);
    int k;
    @(negedge ref_clk_i);
    rd_en_i = 1'b1;
    rd_addr_i = a;
    @(negedge ref_clk_i);
    rd_en_i = 1'b0;
    rd_addr_i = ~a;
    k = 0;
    while (rd_valid_o !== 1'b1 && k < 4) begin
      @(negedge ref_clk_i);
      k++;
    end
    if (rd_valid_o !== 1'b1) begin
      mismatches++;
      $display("mismatch rd_valid_o expected 1 seen %b", rd_valid_o);
      tally_and_finish();
    end
    chk(n, rd_data_o & m, exp & m);
  endtask

  task automatic pick;
    r = {$urandom, $urandom};
    a1 = r[39:0];
    a2 = ~a1;
    s1 = r[55:40];
    s2 = ~s1;
  endtask

  task automatic fill(input bit ecc, cor, mem, ird, input logic [39:0] a, input logic [15:0] s);
    @(negedge ref_clk_i);
    ecc_mode_i = ecc;
    fill_err_correctable_i = cor;
    fill_from_memory_i = mem;
    instruction_fill_flag_i = ird;
    fill_addr_i = a;
    fill_syndrome_i = s;
    fill_err_i = 1'b1;
    @(negedge ref_clk_i);
    fill_err_i = 1'b0;
    fill_addr_i = ~a;
    fill_syndrome_i = ~s;
  endtask

  task automatic cmd(input logic [39:0] a);
    @(negedge ref_clk_i);
    cmd_addr_i = a;
    cmd_addr_parity_err_i = 1'b1;
    @(negedge ref_clk_i);
    cmd_addr_parity_err_i = 1'b0;
    cmd_addr_i = ~a;
  endtask

  task automatic tag_ev(input bit tpe, tcpe, upd);
    @(negedge ref_clk_i);
    {tag_hit_i, status_parity_bit_i, line_dirty_bit_i, line_shared_bit_i} = 4'($urandom);
    {line_valid_bit_i, tag_parity_i} = 2'($urandom);
    tag_bits_i = 19'($urandom);
    if (upd) begin
      tag_used_mask_i = 19'($urandom);
      exp_tc = '0;
      exp_tc[TC_TAG_HI:TC_TAG_LO] = tag_bits_i & tag_used_mask_i;
      exp_tc[TC_TAGP:TC_HIT] = {tag_parity_i, line_valid_bit_i, line_shared_bit_i,
                                line_dirty_bit_i, status_parity_bit_i, tag_hit_i};
    end
    tag_addr_parity_err_i = tpe;
    tag_ctl_parity_err_i = tcpe;
    tag_rd_i = 1'b1;
    @(negedge ref_clk_i);
    tag_rd_i = 1'b0;
    tag_addr_parity_err_i = 1'b0;
    tag_ctl_parity_err_i = 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h2f9e));
    repeat (20) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    rdchk("status_init", ADDR_ERR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0), ~64'h0000000ff0000000);
    rdchk("status_idle", ADDR_ERR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0));
    for (int i = 0; i < 8; i++) begin
      tag_ev(0, 0, 1);
      rdchk("tag_capture", ADDR_TAG_CAP, exp_tc);
    end
    rdchk("unmapped", 40'hfffff00000, 64'h0);
    $display("test tag_follow done");
    pick();
    fill(1, 1, 1, 0, a1, s1);
    rdchk("addr_cor", ADDR_ERR_ADDR, {24'h0, a1});
    rdchk("syn_cor", ADDR_FILL_SYNDROME, {48'h0, s1});
    fill(1, 1, 0, 1, a2, s2);
    rdchk("addr_cor2", ADDR_ERR_ADDR, {24'h0, a1});
    rdchk("status_cor", ADDR_ERR_STATUS, st(1, 0, 0, 0, 0, 1, 0, 0));
    rdchk("status_clr", ADDR_ERR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0));
    $display("test correctable done");
    pick();
    fill(1, 0, 0, 1, a1, s1);
    tag_ev(0, 0, 0);
    fill(1, 1, 1, 0, a2, s2);
    fill(1, 0, 1, 0, a2, s2);
    @(negedge ref_clk_i);
    rst_b_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    rdchk("addr_unc", ADDR_ERR_ADDR, {24'h0, a1});
    rdchk("syn_unc", ADDR_FILL_SYNDROME, {48'h0, s1});
    rdchk("tag_locked", ADDR_TAG_CAP, exp_tc);
    rdchk("status_unc", ADDR_ERR_STATUS, st(0, 1, 0, 0, 0, 0, 1, 1));
    rdchk("status_clr", ADDR_ERR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0));
    $display("test uncorrectable done");
    pick();
    fill(0, 1, 1, 1, a1, s1);
    rdchk("status_par", ADDR_ERR_STATUS, st(0, 1, 0, 0, 0, 1, 1, 0));
    rdchk("status_clr", ADDR_ERR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0));
    cmd(a1);
    cmd(a2);
    rdchk("addr_cmd", ADDR_ERR_ADDR, {24'h0, a1});
    rdchk("status_cmd", ADDR_ERR_STATUS, st(0, 0, 1, 0, 0, 1, 0, 1), M_CMD);
    rdchk("status_clr", ADDR_ERR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0));
    $display("test parity_and_command done");
    for (int sec = 0; sec < 2; sec++) begin
      pick();
      fill(1, 1, 1, 0, a1, s1);
      fill(1, 0, 0, 0, a2, s2);
      if (sec == 1) begin
        cmd(a1);
      end
      rdchk("status_both", ADDR_ERR_STATUS, st(1, 1, 0, 0, 0, 0, 0, sec), M_CMD);
      tag_ev(0, 0, 0);
      rdchk("addr_both", ADDR_ERR_ADDR, {24'h0, a2});
      rdchk("status_unc", ADDR_ERR_STATUS, st(0, 1, 0, 0, 0, 0, 0, sec), M_CMD);
      rdchk("tag_both", ADDR_TAG_CAP, exp_tc);
      rdchk("status_clr", ADDR_ERR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0));
    end
    $display("test both_set done");
    for (int i = 0; i < 2; i++) begin
      tag_ev(i == 0, i == 1, 1);
      tag_ev(0, 0, 0);
      rdchk("tag_err", ADDR_TAG_CAP, exp_tc);
      rdchk("status_tag", ADDR_ERR_STATUS, st(0, 0, 0, i == 0, i == 1, 0, 0, 0), M_TAGERR);
      rdchk("status_clr", ADDR_ERR_STATUS, st(0, 0, 0, 0, 0, 0, 0, 0));
    end
    $display("test tag_parity done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
